// *** rtl/iqc_map.vh ***
// Register offsets, field positions, reset values and timing counts of the correction block.
`ifndef IQC_MAP_VH
`define IQC_MAP_VH
// Register byte offsets on the bus.
`define IQC_CTRL_OFS 8'h00
`define IQC_PIN_CFG_OFS 8'h04
`define IQC_ALARM_STAT_OFS 8'h08
`define IQC_ALARM_CLR_OFS 8'h0c
`define IQC_ALARM_EN_OFS 8'h10
`define IQC_GAIN_OFS 8'h14
`define IQC_PHASE_OFS 8'h18
`define IQC_OFFSET_OFS 8'h1c
`define IQC_LIVE_OFS 8'h20
// Control register fields.
`define IQC_CTRL_FIFO_EN 0
`define IQC_CTRL_QMC_EN 1
// Pin configuration fields.
`define IQC_PIN_ALARM_SEL 7
`define IQC_PIN_FOUR_WIRE 6
// Alarm status, clear and enable layout.
`define IQC_AL_TWO 0
`define IQC_AL_ONE 1
// Field positions of the second path inside the gain and offset words.
`define IQC_Q_LSB 16
// Reset values: unity gain, no phase, no offset.
`define IQC_GAIN_RST 11'h400
`define IQC_PHASE_RST 10'h000
`define IQC_OFFSET_RST 13'h0000
// Initial pointer spacing after a sync of the FIFO.
`define IQC_PTR_INIT 3'h4
// Converter sample rate as a division of the reference clock.
`define IQC_REF_MHZ 250
`define IQC_SAMPLE_MHZ 62
`define IQC_SAMPLE_DIV (`IQC_REF_MHZ / `IQC_SAMPLE_MHZ)
// Fixed point shifts for phase and gain.
`define IQC_PHASE_SHIFT 12
`define IQC_GAIN_SHIFT 10
`endif

// *** rtl/iqc_top.v ***
// Quadrature correction path with input FIFO, pointer alarms and an AHB-Lite register slave.
// Summary of operation
// [R1] Free-running pointers repeat or drop samples on crossing.
// [R2] Two-apart alarm when pointers within two addresses.
// [R3] One-apart alarm when pointers within one address.
// [R4] Both alarms recorded in a readable status register.
// [R5] Alarms raised unclocked, synchronised before any use. The code raises them in alarm_raw_ff, a register clocked by ref_clk_i.
// [R6] Alarm pin only with select set, four-wire clear.
// [R7] Correction applies gain, phase and offset parameters.
// [R8] Gains are 11-bit unsigned, range 0 to 2.
// [R9] Phase is 10-bit signed, range plus/minus 1/8.
// [R10] Offsets are 13-bit signed, -4096 to 4095.
// [R11] Offset added to each path before conversion.
// [R12] Gain applied ahead of the offset addition.
// [R13] FIFO used only in dual-input clock mode.
// [R14] Other modes bypass FIFO; alarms then suppressed.
// [R15] Phase adds scaled opposite path before gain.
// [R16] Result saturates to 14-bit converter range.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "iqc_map.vh"
module iqc_top (
   // Clock and reset.
   input wire ref_clk_i,
   input wire rst_n_i,
   // AHB-Lite slave.
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   // Sample source, same clock domain.
   input wire [13:0] src_i_i,
   input wire [13:0] src_q_i,
   input wire src_valid_i,
   // Corrected samples to the converter cores.
   output wire [13:0] dac_i_o,
   output wire [13:0] dac_q_o,
   output reg dac_valid_o,
   // Shared alarm pin and interrupt.
   output reg alarm_pin_o,
   output reg alarm_pin_oe_o,
   output reg irq_o
);
   // Saturates a wide signed sum to the 14-bit converter range.
   function [13:0] iqc_sat;
      input [17:0] v;
      begin
         if (!v[17] && (v[16:13] != 4'h0)) begin
            iqc_sat = 14'h1fff; // [R16]
         end else if (v[17] && (v[16:13] != 4'hf)) begin
            iqc_sat = 14'h2000; // [R16]
         end else begin
            iqc_sat = v[13:0];
         end
      end
   endfunction

   reg fifo_en_ff; // Dual-input clock mode, FIFO in the path.
   reg qmc_en_ff; // Correction enabled; when low samples pass unchanged.
   reg alarm_sel_ff; // Routes the alarms to the shared pin.
   reg four_wire_ff; // Pin is used as serial output when set.
   reg [1:0] alarm_stat_ff; // Sticky alarm events.
   reg [1:0] alarm_en_ff; // Interrupt enables, same layout.
   reg [10:0] gain_i_ff; // I path gain.
   reg [10:0] gain_q_ff; // Q path gain.
   reg [9:0] phase_ff; // Phase correction.
   reg [12:0] offset_i_ff; // I path offset.
   reg [12:0] offset_q_ff; // Q path offset.

   // Bus address phase captured for the following data phase.
   reg wr_pend_ff;
   reg [7:0] wr_addr_ff;
   wire addr_phase;
   assign addr_phase = hsel_i && htrans_i[1] && hready_i;

   // Sample rate enable from the reference clock divider.
   reg [7:0] div_ff;
   reg sample_en_ff;

   // Input FIFO of I/Q pairs.
   reg [27:0] fifo_mem [0:7];
   reg [2:0] wr_ptr_ff;
   reg [2:0] rd_ptr_ff;
   wire [2:0] ptr_gap;
   reg [1:0] alarm_raw_ff; // Unclocked-in-spirit alarm levels.
   reg [1:0] alarm_s1_ff; // First synchroniser stage.
   reg [1:0] alarm_s2_ff; // Second synchroniser stage.

   // Corrector input selection.
   reg [13:0] in_i;
   reg [13:0] in_q;
   reg in_valid;
   reg v1_ff;
   reg v2_ff;

   // Clear pulse decoded from a bus write; the set still wins below.
   wire [1:0] clr_w;
   assign clr_w = (wr_pend_ff && wr_addr_ff == `IQC_ALARM_CLR_OFS) ? hwdata_i[1:0] : 2'h0;

   // Bus slave: zero wait states, always OKAY, registered read data.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_o <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         // Writes above the register window are dropped here, so they never reach a register.
         wr_pend_ff <= addr_phase && hwrite_i && (haddr_i[31:8] == 24'h0);
         wr_addr_ff <= haddr_i[7:0];
         if (addr_phase && !hwrite_i) begin
            // Unmapped words and upper address space read as zero.
            hrdata_o <= 32'h0;
            if (haddr_i[31:8] == 24'h0) begin
               case (haddr_i[7:0])
                  `IQC_CTRL_OFS: hrdata_o <= {30'h0, qmc_en_ff, fifo_en_ff};
                  `IQC_PIN_CFG_OFS: hrdata_o <= {24'h0, alarm_sel_ff, four_wire_ff, 6'h0};
                  `IQC_ALARM_STAT_OFS: hrdata_o <= {30'h0, alarm_stat_ff}; // [R4]
                  `IQC_ALARM_EN_OFS: hrdata_o <= {30'h0, alarm_en_ff};
                  `IQC_GAIN_OFS: hrdata_o <= {5'h0, gain_q_ff, 5'h0, gain_i_ff};
                  `IQC_PHASE_OFS: hrdata_o <= {22'h0, phase_ff};
                  `IQC_OFFSET_OFS: hrdata_o <= {3'h0, offset_q_ff, 3'h0, offset_i_ff};
                  `IQC_LIVE_OFS: hrdata_o <= {24'h0, ptr_gap, 3'h0, alarm_s2_ff};
                  default: hrdata_o <= 32'h0;
               endcase
            end
         end
      end
   end

   // Register writes in the data phase; the clear register holds no state.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fifo_en_ff <= 1'b1;
         qmc_en_ff <= 1'b1;
         alarm_sel_ff <= 1'b0;
         four_wire_ff <= 1'b0;
         alarm_en_ff <= 2'h0;
         gain_i_ff <= `IQC_GAIN_RST;
         gain_q_ff <= `IQC_GAIN_RST;
         phase_ff <= `IQC_PHASE_RST;
         offset_i_ff <= `IQC_OFFSET_RST;
         offset_q_ff <= `IQC_OFFSET_RST;
      end else if (wr_pend_ff) begin
         case (wr_addr_ff)
            `IQC_CTRL_OFS: begin
               fifo_en_ff <= hwdata_i[`IQC_CTRL_FIFO_EN];
               qmc_en_ff <= hwdata_i[`IQC_CTRL_QMC_EN];
            end
            `IQC_PIN_CFG_OFS: begin
               alarm_sel_ff <= hwdata_i[`IQC_PIN_ALARM_SEL];
               four_wire_ff <= hwdata_i[`IQC_PIN_FOUR_WIRE];
            end
            `IQC_ALARM_EN_OFS: alarm_en_ff <= hwdata_i[1:0];
            `IQC_GAIN_OFS: begin
               gain_i_ff <= hwdata_i[10:0]; // [R8]
               gain_q_ff <= hwdata_i[`IQC_Q_LSB+10:`IQC_Q_LSB]; // [R8]
            end
            `IQC_PHASE_OFS: phase_ff <= hwdata_i[9:0]; // [R9]
            `IQC_OFFSET_OFS: begin
               offset_i_ff <= hwdata_i[12:0]; // [R10]
               offset_q_ff <= hwdata_i[`IQC_Q_LSB+12:`IQC_Q_LSB]; // [R10]
            end
            default: begin
            end
         endcase
      end
   end

   // Divider that makes the converter sample enable, one pulse per period.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_ff <= 8'h00;
         sample_en_ff <= 1'b0;
      end else if (div_ff == `IQC_SAMPLE_DIV - 1) begin
         div_ff <= 8'h00;
         sample_en_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 8'h01;
         sample_en_ff <= 1'b0;
      end
   end

   // FIFO pointers. They wrap freely and never block, so a source that runs fast or
   // slow against the read side overwrites or rereads entries, as the real part does.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= `IQC_PTR_INIT;
         rd_ptr_ff <= 3'h0;
      end else if (!fifo_en_ff) begin
         // Bypass modes hold the pointers at their sync spacing.
         wr_ptr_ff <= `IQC_PTR_INIT; // [R14]
         rd_ptr_ff <= 3'h0;
      end else begin
         if (src_valid_i) begin
            wr_ptr_ff <= wr_ptr_ff + 3'h1; // [R1]
         end
         if (sample_en_ff) begin
            rd_ptr_ff <= rd_ptr_ff + 3'h1; // [R1]
         end
      end
   end

   // Storage has no reset; after a sync the read pointer starts on entries 0 to 3, which no write has reached yet.
   always @(posedge ref_clk_i) begin
      if (fifo_en_ff && src_valid_i) begin
         fifo_mem[wr_ptr_ff] <= {src_q_i, src_i_i}; // [R13]
      end
   end

   assign ptr_gap = wr_ptr_ff - rd_ptr_ff;

   // Proximity alarms, then a two-stage synchroniser before anything reads them.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_raw_ff <= 2'h0;
         alarm_s1_ff <= 2'h0;
         alarm_s2_ff <= 2'h0;
      end else begin
         alarm_raw_ff[`IQC_AL_TWO] <= fifo_en_ff && (ptr_gap <= 3'h2 || ptr_gap >= 3'h6); // [R2] [R14]
         alarm_raw_ff[`IQC_AL_ONE] <= fifo_en_ff && (ptr_gap <= 3'h1 || ptr_gap == 3'h7); // [R3] [R14]
         alarm_s1_ff <= alarm_raw_ff; // [R5]
         alarm_s2_ff <= alarm_s1_ff; // [R5]
      end
   end

   // Sticky status with set winning over a clear in the same cycle, plus the interrupt.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_stat_ff <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         alarm_stat_ff <= (alarm_stat_ff & ~clr_w) | alarm_s2_ff; // [R4]
         irq_o <= |(((alarm_stat_ff & ~clr_w) | alarm_s2_ff) & alarm_en_ff);
      end
   end

   // Shared pin carries the alarm only when selected and not in four-wire mode.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_pin_o <= 1'b0;
         alarm_pin_oe_o <= 1'b0;
      end else begin
         alarm_pin_oe_o <= alarm_sel_ff && !four_wire_ff; // [R6]
         alarm_pin_o <= alarm_sel_ff && !four_wire_ff && (|alarm_s2_ff); // [R6]
      end
   end

   // Source of the corrector: FIFO output in dual-input mode, else the source directly.
   always @* begin
      if (fifo_en_ff) begin
         in_i = fifo_mem[rd_ptr_ff][13:0]; // [R13]
         in_q = fifo_mem[rd_ptr_ff][27:14];
         in_valid = sample_en_ff;
      end else begin
         in_i = src_i_i; // [R14]
         in_q = src_q_i;
         in_valid = src_valid_i;
      end
   end

   // Valid strobe follows the three pipeline stages.
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         v1_ff <= 1'b0;
         v2_ff <= 1'b0;
         dac_valid_o <= 1'b0;
      end else begin
         v1_ff <= in_valid;
         v2_ff <= v1_ff;
         dac_valid_o <= v2_ff;
      end
   end

   // Two identical correction lanes: phase, then gain, then offset with saturation.
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : lane
         wire signed [13:0] own;
         wire signed [13:0] other;
         wire [10:0] gain;
         wire signed [12:0] offset;
         wire signed [23:0] ph_prod;
         wire signed [31:0] g_prod;
         wire signed [17:0] sum;
         wire signed [14:0] ph_term; // Rounded phase term, sign extended to the stage width.
         reg signed [14:0] ph_ff; // After phase stage.
         reg signed [16:0] gn_ff; // After gain stage.
         reg [13:0] out_ff; // Converter word.
         assign own = (g == 0) ? in_i : in_q;
         assign other = (g == 0) ? in_q : in_i;
         assign gain = (g == 0) ? gain_i_ff : gain_q_ff;
         assign offset = (g == 0) ? offset_i_ff : offset_q_ff;
         assign ph_prod = other * $signed(phase_ff); // [R15]
         // Part-selects are unsigned, so the sign is copied by hand; the bit below the cut rounds half up.
         assign ph_term = {{3{ph_prod[23]}}, ph_prod[23:`IQC_PHASE_SHIFT]} + {14'h0, ph_prod[`IQC_PHASE_SHIFT-1]};
         assign g_prod = ph_ff * $signed({1'b0, gain}); // [R8]
         // Fits easily: 17 bits plus 13 bits signed into 18 bits.
         assign sum = {gn_ff[16], gn_ff} + {{5{offset[12]}}, offset}; // [R11]
         // Stage registers: phase, gain, then offset, in the order that keeps headroom.
         // Each stage loads only with its own valid, so the lanes hold between samples and a
         // register write between two samples cannot disturb the word already at the converter.
         always @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               ph_ff <= 15'h0000;
               gn_ff <= 17'h00000;
               out_ff <= 14'h0000;
            end else begin
               if (in_valid) begin
                  if (!qmc_en_ff) begin
                     ph_ff <= {own[13], own};
                  end else begin
                     ph_ff <= {own[13], own} + ph_term; // [R9] [R15]
                  end
               end
               if (v1_ff) begin
                  if (!qmc_en_ff) begin
                     gn_ff <= {{2{ph_ff[14]}}, ph_ff};
                  end else begin
                     gn_ff <= g_prod[`IQC_GAIN_SHIFT+16:`IQC_GAIN_SHIFT]; // [R7] [R12]
                  end
               end
               if (v2_ff) begin
                  if (!qmc_en_ff) begin
                     out_ff <= iqc_sat({gn_ff[16], gn_ff}); // [R16]
                  end else begin
                     out_ff <= iqc_sat(sum); // [R11] [R12] [R16]
                  end
               end
            end
         end
      end
   endgenerate

   assign dac_i_o = lane[0].out_ff;
   assign dac_q_o = lane[1].out_ff;

endmodule // iqc_top

// *** sim/iqc_conv_model.sv ***
// Converter core model that latches each corrected I/Q pair offered to it.
`timescale 1ns/1ns
module iqc_conv_model (
   // Clock and reset.
   input wire clk_i,
   input wire rst_n_i,
   // Corrected sample lanes.
   input wire [13:0] dac_i_i,
   input wire [13:0] dac_q_i,
   input wire valid_i
);
   int n; // Number of samples taken so far.
   logic [13:0] i_ff; // Last I sample converted.
   logic [13:0] q_ff; // Last Q sample converted.
   // The core takes a sample only on the valid pulse, which marks the cycle a new pair reaches the lanes.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         n <= 0;
         i_ff <= 14'h0;
         q_ff <= 14'h0;
      end else if (valid_i) begin
         n <= n + 1;
         i_ff <= dac_i_i;
         q_ff <= dac_q_i;
      end
   end
endmodule // iqc_conv_model

// *** sim/iqc_top_properties.sv ***
// Port-level checker of the correction block, bound to its top module.
`timescale 1ns/1ns
module iqc_top_properties (
   // Clock and reset.
   input wire ref_clk_i,
   input wire rst_n_i,
   // Register bus.
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   // Sample lanes, pin and interrupt.
   input wire [13:0] dac_i_o,
   input wire [13:0] dac_q_o,
   input wire dac_valid_o,
   input wire alarm_pin_o,
   input wire alarm_pin_oe_o,
   input wire irq_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // A transfer is taken only when selected, non-idle and the bus is ready.
   wire addr_ph = hsel_i && htrans_i[1] && hready_i;
   // Address phase of a write to one register, followed by its data phase.
   sequence s_wr(a);
      addr_ph && hwrite_i && haddr_i == {24'h0, a} ##1 1'b1;
   endsequence
   chk_ready_okay: assert property (hreadyout_o && !hresp_o) else $error("bus stalled or errored");
   chk_unmapped_zero: assert property (addr_ph && !hwrite_i && haddr_i == 32'h40 |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (!$past(addr_ph && !hwrite_i) |-> $stable(hrdata_o))
      else $error("read data moved without a read");
   chk_pin_gated: assert property (alarm_pin_o |-> alarm_pin_oe_o) else $error("pin driven while not routed");
   chk_oe_on: assert property (s_wr(8'h04) ##0 hwdata_i[7:6] == 2'b10 |-> ##2 alarm_pin_oe_o)
      else $error("alarm pin not enabled");
   chk_oe_off: assert property (s_wr(8'h04) ##0 hwdata_i[7:6] != 2'b10 |-> ##2 !alarm_pin_oe_o)
      else $error("alarm pin enabled wrongly");
   chk_irq_masked: assert property (s_wr(8'h10) ##0 hwdata_i[1:0] == 2'b00 |-> ##2 !irq_o)
      else $error("interrupt high while masked");
   chk_lane_hold: assert property (!dac_valid_o |-> $stable({dac_i_o, dac_q_o}))
      else $error("lanes moved without valid");
endmodule // iqc_top_properties
bind iqc_top iqc_top_properties u_chk (.ref_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
   .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .dac_i_o, .dac_q_o, .dac_valid_o, .alarm_pin_o, .alarm_pin_oe_o,
   .irq_o);

// *** sim/testbench.sv ***
// Self-checking bench: register access, alarms, pin routing and correction arithmetic.
`timescale 1ns/1ns
`include "iqc_map.vh"
module testbench;
   logic ref_clk, rst_n, hsel, hwrite, src_v;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [13:0] src_i, src_q, dac_i, dac_q;
   logic hready, hresp, dac_v, pin, pin_oe, irq;
   int n_mismatch, n_checks, k;
   int r[8];
   // Register offsets read after reset, with their expected reset contents.
   logic [7:0] ra[7] = '{`IQC_CTRL_OFS, `IQC_PIN_CFG_OFS, `IQC_ALARM_EN_OFS, `IQC_GAIN_OFS, `IQC_PHASE_OFS,
      `IQC_OFFSET_OFS, 8'h40};
   logic [31:0] rv[7] = '{32'h3, 32'h0, 32'h0, 32'h04000400, 32'h0, 32'h0, 32'h0};
   // Sample cases: I, Q, gain I, gain Q, phase, offset I, offset Q, correction on.
   int cs[6][8] = '{'{1000, -2000, 1024, 1024, 0, 0, 0, 1}, '{4000, -4000, 512, 512, 0, 4095, -4096, 1},
      '{2000, 1000, 1024, 1024, 511, 0, 0, 1}, '{2000, 1000, 1024, 1024, -512, 0, 0, 1},
      '{8191, -8192, 2047, 2047, 0, 4095, -4096, 1}, '{1234, -77, 512, 512, 100, 300, -300, 0}};
   iqc_top u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .src_i_i(src_i), .src_q_i(src_q), .src_valid_i(src_v),
      .dac_i_o(dac_i), .dac_q_o(dac_q), .dac_valid_o(dac_v), .alarm_pin_o(pin), .alarm_pin_oe_o(pin_oe),
      .irq_o(irq));
   iqc_conv_model u_conv (.clk_i(ref_clk), .rst_n_i(rst_n), .dac_i_i(dac_i), .dac_q_i(dac_q), .valid_i(dac_v));
   // Free-running 250 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Prints the verdict and stops.
   task end_sim;
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Compares one value with its expectation.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Waits for hready high at a rising edge; a slave that never answers ends the run.
   task wait_rdy;
      int c;
      c = 0;
      do begin @(posedge ref_clk); c++; end while (hready !== 1'b1 && c < 50);
      if (c >= 50) begin n_mismatch++; end_sim; end
   endtask
   // Single word write: address phase, then data phase.
   task wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= 1'b1;
      wait_rdy;
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wait_rdy;
   endtask
   // Single word read; data is taken at the edge that ends the data phase.
   task rd(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= 1'b0;
      wait_rdy;
      hsel <= 1'b0; htrans <= 2'h0;
      wait_rdy;
      d = hrdata;
   endtask
   // Offers one I/Q pair and waits a bounded time for the converter to take its next sample.
   task smp(input logic [13:0] si, input logic [13:0] sq);
      int c, j;
      c = u_conv.n;
      src_i <= si; src_q <= sq; src_v <= 1'b1;
      @(posedge ref_clk);
      src_v <= 1'b0;
      for (j = 0; j < 40 && u_conv.n == c; j++) @(posedge ref_clk);
      if (u_conv.n == c) begin n_mismatch++; end_sim; end
   endtask
   // Expected lane: phase term from the other path, then gain, then offset, then saturation.
   function automatic logic [13:0] fx(input int own, oth, gn, ph, off, en);
      int s;
      if (en == 0) return own[13:0];
      s = (((own + ((oth * ph + 2048) >>> 12)) * gn) >>> 10) + off;
      if (s > 8191) s = 8191;
      else if (s < -8192) s = -8192;
      return s[13:0];
   endfunction
   // Main sequence.
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      src_i = 14'h0; src_q = 14'h0; src_v = 1'b0; n_mismatch = 0; n_checks = 0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (k = 0; k < 7; k++) begin rd(ra[k], v); chk(v, rv[k]); end
      // The FIFO runs with no writes, so the read pointer sweeps past the write pointer.
      repeat (40) @(posedge ref_clk);
      rd(`IQC_ALARM_STAT_OFS, v); chk(v, 32'h3);
      wr(`IQC_ALARM_EN_OFS, 32'h3); repeat (4) @(posedge ref_clk); chk(irq, 1'b1);
      wr(`IQC_ALARM_EN_OFS, 32'h0); repeat (4) @(posedge ref_clk); chk(irq, 1'b0);
      wr(`IQC_PIN_CFG_OFS, 32'h80); repeat (3) @(posedge ref_clk); chk(pin_oe, 1'b1);
      // The free-running pointers raise the alarm for most of each lap, so wait for it a bounded time.
      for (k = 0; k < 40 && pin !== 1'b1; k++) @(posedge ref_clk);
      chk(pin, 1'b1);
      wr(`IQC_PIN_CFG_OFS, 32'hc0); repeat (3) @(posedge ref_clk); chk(pin_oe, 1'b0); chk(pin, 1'b0);
      // Bypass holds the pointers apart, so a clear must stick.
      wr(`IQC_CTRL_OFS, 32'h2); repeat (8) @(posedge ref_clk); wr(`IQC_ALARM_CLR_OFS, 32'h3);
      rd(`IQC_ALARM_STAT_OFS, v); chk(v, 32'h0);
      rd(`IQC_LIVE_OFS, v); chk(v, 32'h80);
      for (k = 0; k < 6; k++) begin
         r = cs[k];
         wr(`IQC_CTRL_OFS, r[7] != 0 ? 32'h2 : 32'h0);
         wr(`IQC_GAIN_OFS, {5'h0, r[3][10:0], 5'h0, r[2][10:0]});
         wr(`IQC_PHASE_OFS, {22'h0, r[4][9:0]});
         wr(`IQC_OFFSET_OFS, {3'h0, r[6][12:0], 3'h0, r[5][12:0]});
         smp(r[0][13:0], r[1][13:0]);
         chk(u_conv.i_ff, fx(r[0], r[1], r[2], r[4], r[5], r[7]));
         chk(u_conv.q_ff, fx(r[1], r[0], r[3], r[4], r[6], r[7]));
      end
      // Dual-input mode with correction off: once every entry holds one pair, whatever the read
      // pointer lands on must come through the FIFO unchanged.
      wr(`IQC_CTRL_OFS, 32'h1);
      for (k = 0; k < 10; k++) smp(14'h0123, 14'h3abc);
      chk(u_conv.i_ff, 32'h0123);
      chk(u_conv.q_ff, 32'h3abc);
      end_sim;
   end
endmodule // testbench
